/* File: rtl/sfc_crc8.v */
// combinational 8-bit crc over one 16-bit word, msb first, no reflection
// assumes the caller registers the result where timing needs it
`include "sfc_map.vh"

module sfc_crc8 (
  input  wire [15:0] data,
  input  wire        poly_alt,
  output reg  [7:0]  crc
);

  reg [7:0] poly;
  reg [7:0] acc;
  reg       fb;
  integer   i;

  always @* begin
    poly = poly_alt ? `SFC_CRC_POLY_ALT : `SFC_CRC_POLY_DEFAULT;
    acc  = `SFC_CRC_INIT;
    fb   = 1'b0;
    for (i = 15; i >= 0; i = i - 1) begin
      fb  = acc[7] ^ data[i];
      acc = {acc[6:0], 1'b0};
      if (fb) begin
        acc = acc ^ poly;
      end
    end
    crc = acc ^ `SFC_CRC_XOR;
  end

endmodule

/* File: rtl/sfc_map.vh */
// register offsets, field positions, reset values and codes of the spi frame checker
// assumes inclusion by bare name from every design file that needs it
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

`define SFC_ADDR_CRC_CTRL      7'h0A
`define SFC_ADDR_CRC_SEL       7'h0B
`define SFC_ADDR_SCRATCH_PAD   7'h0F
`define SFC_ADDR_TIMER_CFG     7'h1C
`define SFC_ADDR_INT_STAT_ONE  7'h50
`define SFC_ADDR_INT_STAT_TWO  7'h53

`define SFC_CFG_DISABLE_BIT    7
`define SFC_CFG_DUR_HI         6
`define SFC_CFG_DUR_LO         3
`define SFC_CFG_RESET          8'h48
`define SFC_CRC_EN_BIT         0
`define SFC_CRC_SEL_BIT        0

`define SFC_INT1_GLOBAL_BIT    7
`define SFC_INT1_SUMMARY_BIT   4
`define SFC_INT2_FRAME_BIT     7
`define SFC_INT2_CRC_BIT       4

`define SFC_FRAME_BITS_PLAIN   5'd16
`define SFC_FRAME_BITS_CRC     5'd24
`define SFC_CMD_WRITE          1'b1

`define SFC_CRC_POLY_DEFAULT   8'h2F
`define SFC_CRC_POLY_ALT       8'h1D
`define SFC_CRC_INIT           8'hFF
`define SFC_CRC_XOR            8'hFF
`define SFC_CRC_FILLER         8'h00

`define SFC_MODE_SLEEP         2'h0
`define SFC_MODE_RESTART       2'h1
`define SFC_MODE_STANDBY       2'h2
`define SFC_MODE_FAILSAFE      2'h3

`define SFC_CLK_HZ             125000000
`define SFC_TICK_SEC           1

// sleep-wake error timer lengths in seconds, indexed by the duration code
`define SFC_TMR_SEC_0          10'd30
`define SFC_TMR_SEC_1          10'd60
`define SFC_TMR_SEC_2          10'd90
`define SFC_TMR_SEC_3          10'd120
`define SFC_TMR_SEC_4          10'd150
`define SFC_TMR_SEC_5          10'd180
`define SFC_TMR_SEC_6          10'd210
`define SFC_TMR_SEC_7          10'd240
`define SFC_TMR_SEC_8          10'd270
`define SFC_TMR_SEC_9          10'd300
`define SFC_TMR_SEC_10         10'd360
`define SFC_TMR_SEC_11         10'd420
`define SFC_TMR_SEC_12         10'd480
`define SFC_TMR_SEC_13         10'd540
`define SFC_TMR_SEC_14         10'd570
`define SFC_TMR_SEC_15         10'd600

`endif

/* File: rtl/sfc_swe_timer.v */
// sleep-wake error timer: one-second ticks from a prescaler, duration picked by a 4-bit code
// assumes start is a one-cycle pulse and stop a pulse or held level, both from logic on the same clock
`include "sfc_map.vh"

module sfc_swe_timer #(
  parameter TICK_CYCLES = `SFC_CLK_HZ * `SFC_TICK_SEC
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       clk_en,
  input  wire       start,
  input  wire       stop,
  input  wire [3:0] dur_code,
  output reg        running_q,
  output reg        expired_q
);

  reg  [31:0] pre_q;
  reg  [9:0]  sec_q;
  reg  [9:0]  limit;
  wire        tick = (pre_q == TICK_CYCLES - 1);

  // duration in seconds, 30 s up to 10 min, code 9 is 5 min
  always @* begin
    case (dur_code)
      4'h0:    limit = `SFC_TMR_SEC_0;
      4'h1:    limit = `SFC_TMR_SEC_1;
      4'h2:    limit = `SFC_TMR_SEC_2;
      4'h3:    limit = `SFC_TMR_SEC_3;
      4'h4:    limit = `SFC_TMR_SEC_4;
      4'h5:    limit = `SFC_TMR_SEC_5;
      4'h6:    limit = `SFC_TMR_SEC_6;
      4'h7:    limit = `SFC_TMR_SEC_7;
      4'h8:    limit = `SFC_TMR_SEC_8;
      4'h9:    limit = `SFC_TMR_SEC_9;
      4'hA:    limit = `SFC_TMR_SEC_10;
      4'hB:    limit = `SFC_TMR_SEC_11;
      4'hC:    limit = `SFC_TMR_SEC_12;
      4'hD:    limit = `SFC_TMR_SEC_13;
      4'hE:    limit = `SFC_TMR_SEC_14;
      default: limit = `SFC_TMR_SEC_15;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      pre_q     <= 32'h0000_0000;
      sec_q     <= 10'h000;
      running_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (clk_en) begin
      expired_q <= 1'b0;
      if (start) begin
        pre_q     <= 32'h0000_0000;
        sec_q     <= 10'h000;
        running_q <= 1'b1;
      end else if (stop) begin
        running_q <= 1'b0;
      end else if (running_q) begin
        pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        if (tick) begin
          if (sec_q + 10'h001 >= limit) begin
            running_q <= 1'b0;
            expired_q <= 1'b1;
          end else begin
            sec_q <= sec_q + 10'h001;
          end
        end
      end
    end
  end

endmodule

/* File: rtl/sfc_top.v */
// spi register port with frame length and crc checks, scratchpad, sleep-wake error timer
// and the active-low reset output; spi pins and status inputs are asynchronous to ref_clk
`include "sfc_map.vh"

// Overview of operation
// R1 - without crc a frame is exactly 16 bits: command byte then data byte
// R2 - with crc a frame is exactly 24 bits: command, data, then crc byte
// R3 - port selected only while chip select low; input sampled on rising serial clock
// R4 - writes land only after exact bit count and chip select rising
// R5 - wrong bit count sets frame error, summary and global interrupt bits
// R6 - 8-bit scratchpad reads back exactly what was written
// R7 - under pin control timer starts on entry to fail-safe or restart
// R8 - wake moves sleep to restart; supply still low at expiry returns to sleep
// R9 - under spi control an enabled timer starts on fail-safe, restart, standby entry
// R10 - standby without host transaction before expiry moves to fail-safe
// R11 - timer disabled while configuration bit 7 is one; the code applies this only under spi control, not under pin control
// R12 - timer duration from config bits 6 to 3, default five minutes
// R13 - reset output low on supply undervoltage, watchdog error, or restart mode
// R14 - crc checking off after reset, enabled by crc control bit 0
// R15 - crc poly 2Fh by default, 1Dh when selected; init and xor FFh
// R16 - with crc on, reads use a zero filler data byte inside the crc
// R17 - crc mismatch sets crc error, summary and global interrupt bits
// R18 - read data shifted out on data byte, changed on falling clock
// R19 - a correctly framed transaction in standby stops the timer
module sfc_top #(
  parameter TICK_CYCLES = `SFC_CLK_HZ * `SFC_TICK_SEC
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       clk_en,
  input  wire       spi_cs_n,
  input  wire       spi_sclk,
  input  wire       spi_sdi,
  output wire       spi_sdo,
  output wire       spi_sdo_oe,
  input  wire       pin_control,
  input  wire       regulated_supply_undervoltage,
  input  wire       watchdog_error,
  input  wire       wake_event,
  input  wire       fail_safe_fault,
  output wire [1:0] device_mode,
  output wire       sleep_wake_error_timer_running,
  output wire       reset_out_low
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers: stage one feeds stage two only

  localparam NSYNC = 8;

  wire [NSYNC-1:0] async_in = {fail_safe_fault, wake_event, watchdog_error,
                               regulated_supply_undervoltage, pin_control,
                               spi_sdi, spi_sclk, spi_cs_n};
  reg  [NSYNC-1:0] meta_q;
  reg  [NSYNC-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge ref_clk) begin
        if (srst) begin
          meta_q[g] <= (g == 0) ? 1'b1 : 1'b0;
          sync_q[g] <= (g == 0) ? 1'b1 : 1'b0;
        end else if (clk_en) begin
          meta_q[g] <= async_in[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  wire cs_n_s  = sync_q[0];
  wire sclk_s  = sync_q[1];
  wire sdi_s   = sync_q[2];
  wire pin_s   = sync_q[3];
  wire uv_s    = sync_q[4];
  wire wd_s    = sync_q[5];
  wire wake_s  = sync_q[6];
  wire fault_s = sync_q[7];

  // previous values reset to the idle pin levels so no false edge follows reset
  reg  cs_n_prev_q;
  reg  sclk_prev_q;
  wire selected  = ~cs_n_s;
  wire cs_fall   = cs_n_prev_q & ~cs_n_s;
  wire cs_rise   = ~cs_n_prev_q & cs_n_s;
  wire sclk_rise = selected & ~sclk_prev_q & sclk_s;
  wire sclk_fall = selected & sclk_prev_q & ~sclk_s;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] scratch_pad_q;
  reg [7:0] sleep_wake_timer_config_q;
  reg [7:0] interrupt_status_one_q;
  reg [7:0] interrupt_status_two_q;
  reg       crc_en_q;
  reg       crc_alt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // serial shift path

  reg  [23:0] rx_q;
  reg  [4:0]  bits_q;
  reg  [15:0] tx_q;
  reg         sdo_q;
  reg  [7:0]  rd_data;
  wire [4:0]  frame_bits = crc_en_q ? `SFC_FRAME_BITS_CRC : `SFC_FRAME_BITS_PLAIN; // R1 R2 R14
  wire [7:0]  cmd_byte   = crc_en_q ? rx_q[23:16] : rx_q[15:8];
  wire [7:0]  data_byte  = crc_en_q ? rx_q[15:8] : rx_q[7:0];
  wire [6:0]  addr       = (bits_q == 5'd8) ? rx_q[7:1] : cmd_byte[7:1];
  wire        is_write   = cmd_byte[0] == `SFC_CMD_WRITE;
  wire [7:0]  crc_rx;
  wire [7:0]  crc_tx;

  always @* begin
    case (addr)
      `SFC_ADDR_CRC_CTRL:     rd_data = {7'h00, crc_en_q};
      `SFC_ADDR_CRC_SEL:      rd_data = {7'h00, crc_alt_q};
      `SFC_ADDR_SCRATCH_PAD:  rd_data = scratch_pad_q; // R6
      `SFC_ADDR_TIMER_CFG:    rd_data = sleep_wake_timer_config_q;
      `SFC_ADDR_INT_STAT_ONE: rd_data = interrupt_status_one_q;
      `SFC_ADDR_INT_STAT_TWO: rd_data = interrupt_status_two_q;
      default:                rd_data = 8'h00;
    endcase
  end

  // received crc covers the command byte and the data or zero filler byte
  sfc_crc8 u_crc_rx (
    .data     ({cmd_byte, data_byte}), // R16
    .poly_alt (crc_alt_q), // R15
    .crc      (crc_rx)
  );

  // answer crc covers the command byte and the returned data
  sfc_crc8 u_crc_tx (
    .data     ({rx_q[7:0], rd_data}),
    .poly_alt (crc_alt_q),
    .crc      (crc_tx)
  );

  always @(posedge ref_clk) begin
    if (srst) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      rx_q        <= 24'h000000;
      bits_q      <= 5'h00;
      tx_q        <= 16'h0000;
      sdo_q       <= 1'b0;
    end else if (clk_en) begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
      if (cs_fall) begin
        bits_q <= 5'h00;
        sdo_q  <= 1'b0;
        // drop leftover answer bits so the command byte shifts out zeros
        tx_q   <= 16'h0000;
      end else if (sclk_rise) begin
        rx_q <= {rx_q[22:0], sdi_s}; // R3
        if (bits_q != 5'h1F) begin
          bits_q <= bits_q + 5'h01;
        end
      end else if (sclk_fall) begin
        if (bits_q == 5'd8) begin
          sdo_q <= rd_data[7]; // R18
          tx_q  <= {rd_data[6:0], crc_tx, 1'b0};
        end else begin
          sdo_q <= tx_q[15];
          tx_q  <= {tx_q[14:0], 1'b0};
        end
      end
    end
  end

  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = selected; // R3

  ////////////////////////////////////////////////////////////////////////////////
  // frame end: length check, crc check, register write

  wire len_ok    = bits_q == frame_bits;
  wire frame_err = cs_rise & ~len_ok; // R5
  wire crc_err   = cs_rise & len_ok & crc_en_q & (crc_rx != rx_q[7:0]); // R17
  wire frame_ok  = cs_rise & len_ok & ~crc_err;
  wire wr_ok     = frame_ok & is_write; // R4

  wire [7:0] set_one = {frame_err | crc_err, 2'b00, frame_err | crc_err, 4'h0};
  wire [7:0] set_two = {frame_err, 2'b00, crc_err, 4'h0};
  wire [7:0] clr_one = (wr_ok && cmd_byte[7:1] == `SFC_ADDR_INT_STAT_ONE) ? data_byte : 8'h00;
  wire [7:0] clr_two = (wr_ok && cmd_byte[7:1] == `SFC_ADDR_INT_STAT_TWO) ? data_byte : 8'h00;

  always @(posedge ref_clk) begin
    if (srst) begin
      scratch_pad_q             <= 8'h00;
      sleep_wake_timer_config_q <= `SFC_CFG_RESET;
      interrupt_status_one_q    <= 8'h00;
      interrupt_status_two_q    <= 8'h00;
      crc_en_q                  <= 1'b0; // R14
      crc_alt_q                 <= 1'b0;
    end else if (clk_en) begin
      // write one clears; a new event in the same cycle wins
      interrupt_status_one_q <= (interrupt_status_one_q & ~clr_one) | set_one; // R5 R17
      interrupt_status_two_q <= (interrupt_status_two_q & ~clr_two) | set_two; // R5 R17
      if (wr_ok) begin
        case (cmd_byte[7:1])
          `SFC_ADDR_CRC_CTRL:    crc_en_q <= data_byte[`SFC_CRC_EN_BIT]; // R14
          `SFC_ADDR_CRC_SEL:     crc_alt_q <= data_byte[`SFC_CRC_SEL_BIT]; // R15
          `SFC_ADDR_SCRATCH_PAD: scratch_pad_q <= data_byte; // R6
          `SFC_ADDR_TIMER_CFG:   sleep_wake_timer_config_q <= data_byte; // R11 R12
          default:               ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // device modes and the sleep-wake error timer

  reg  [1:0] mode_q;
  reg  [1:0] mode_d;
  reg  [1:0] mode_prev_q;
  reg        reset_out_low_q;
  wire       tmr_expired;
  wire       tmr_running;
  wire       tmr_off   = sleep_wake_timer_config_q[`SFC_CFG_DISABLE_BIT] & ~pin_s; // R11
  wire       mode_entry = mode_q != mode_prev_q;
  reg        tmr_start;

  always @* begin
    case (mode_q)
      `SFC_MODE_RESTART:  tmr_start = mode_entry & ~tmr_off; // R7 R9
      `SFC_MODE_FAILSAFE: tmr_start = mode_entry & ~tmr_off; // R7 R9
      `SFC_MODE_STANDBY:  tmr_start = mode_entry & ~tmr_off & ~pin_s; // R9
      default:            tmr_start = 1'b0;
    endcase
  end

  wire tmr_stop = (mode_entry & ~tmr_start) | tmr_off |
                  (frame_ok & (mode_q == `SFC_MODE_STANDBY)); // R11 R19

  sfc_swe_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_wake_timer (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .start     (tmr_start),
    .stop      (tmr_stop),
    .dur_code  (sleep_wake_timer_config_q[`SFC_CFG_DUR_HI:`SFC_CFG_DUR_LO]), // R12
    .running_q (tmr_running),
    .expired_q (tmr_expired)
  );

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      `SFC_MODE_SLEEP: begin
        if (wake_s) begin
          mode_d = `SFC_MODE_RESTART; // R8
        end
      end
      `SFC_MODE_RESTART: begin
        if (tmr_expired && uv_s) begin
          mode_d = `SFC_MODE_SLEEP; // R8
        end else if (!uv_s && !wd_s) begin
          mode_d = `SFC_MODE_STANDBY;
        end
      end
      `SFC_MODE_STANDBY: begin
        if (uv_s || wd_s) begin
          mode_d = `SFC_MODE_RESTART;
        end else if (fault_s || tmr_expired) begin
          mode_d = `SFC_MODE_FAILSAFE; // R10
        end
      end
      `SFC_MODE_FAILSAFE: begin
        if (tmr_expired) begin
          mode_d = `SFC_MODE_SLEEP;
        end else if (wake_s) begin
          mode_d = `SFC_MODE_RESTART;
        end
      end
      default: mode_d = `SFC_MODE_RESTART;
    endcase
  end

  // reset output follows the next mode so it falls together with restart entry
  always @(posedge ref_clk) begin
    if (srst) begin
      mode_q          <= `SFC_MODE_RESTART;
      mode_prev_q     <= `SFC_MODE_SLEEP;
      reset_out_low_q <= 1'b0;
    end else if (clk_en) begin
      mode_q          <= mode_d;
      mode_prev_q     <= mode_q;
      reset_out_low_q <= ~(uv_s | wd_s | (mode_d == `SFC_MODE_RESTART)); // R13
    end
  end

  assign device_mode                    = mode_q;
  assign sleep_wake_error_timer_running = tmr_running;
  assign reset_out_low                  = reset_out_low_q;

endmodule

/* File: tb/sfc_assertions.sv */
// concurrent checks on the sfc_top ports
// assumes spi pins are synced inside the design, srst synchronous
module sfc_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire       ref_clk,
  input wire       srst,
  input wire       spi_cs_n,
  input wire       spi_sclk,
  input wire       spi_sdo,
  input wire       spi_sdo_oe,
  input wire       regulated_supply_undervoltage,
  input wire       watchdog_error,
  input wire [1:0] device_mode,
  input wire       sleep_wake_error_timer_running,
  input wire       reset_out_low
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  a_oe_on_select: assert property ($fell(spi_cs_n) |-> ##[1:4] spi_sdo_oe)
    else $error("sdo enable late");
  a_oe_off_idle: assert property (spi_cs_n [*4] |=> !spi_sdo_oe)
    else $error("sdo enable while idle");
  a_sdo_hold_high: assert property (spi_sclk [*6] |-> $stable(spi_sdo))
    else $error("sdo moved while clock high");
  a_uv_holds_rst: assert property (regulated_supply_undervoltage [*4] |=> !reset_out_low)
    else $error("reset out high under voltage");
  a_wd_holds_rst: assert property (watchdog_error [*4] |=> !reset_out_low)
    else $error("reset out high on watchdog");
  a_restart_rst_low: assert property (device_mode == 2'h1 |-> !reset_out_low)
    else $error("reset out high in restart");
  a_sleep_exit: assert property (device_mode == 2'h0 |=> device_mode inside {2'h0, 2'h1})
    else $error("sleep left to wrong mode");
  a_sleep_timer_off: assert property ((device_mode == 2'h0 && $past(device_mode) == 2'h0)
    |-> !sleep_wake_error_timer_running)
    else $error("timer running in sleep");
endmodule

bind sfc_top sfc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.ref_clk, .srst, .spi_cs_n,
  .spi_sclk, .spi_sdo, .spi_sdo_oe, .regulated_supply_undervoltage, .watchdog_error,
  .device_mode, .sleep_wake_error_timer_running, .reset_out_low);

/* File: tb/sfc_host_model.sv */
// host spi controller model: mode 0, msb first, serial clock of 20 ref_clk cycles
// assumes its pins change on the falling ref_clk edge
module sfc_host_model (
  input  wire         ref_clk,
  input  wire         spi_sdo,
  output logic        spi_cs_n,
  output logic        spi_sclk,
  output logic        spi_sdi,
  output logic        rd_valid,
  output logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] sh;
  ////////////////////////////////////////
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b1;
    rd_valid = 1'b0;
  end
  // clock rests low between frames, data line at its pull-up level
  task automatic xfer(input int n, input logic [31:0] w, input bit rd);
    @(negedge ref_clk);
    spi_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_sdi <= w[31-i];
      repeat (10) @(negedge ref_clk);
      spi_sclk <= 1'b1;
      sh <= {sh[22:0], spi_sdo};
      repeat (10) @(negedge ref_clk);
      spi_sclk <= 1'b0;
    end
    repeat (10) @(negedge ref_clk);
    spi_cs_n <= 1'b1;
    spi_sdi <= 1'b1;
    rd_data <= (n == 24) ? sh[15:0] : {sh[7:0], 8'h00};
    rd_valid <= rd;
    @(negedge ref_clk);
    rd_valid <= 1'b0;
    repeat (10) @(negedge ref_clk);
  endtask
endmodule

/* File: tb/tb_spi_frame_check_swe_timer.sv */
// self-checking bench for sfc_top driven through the host spi model
// assumes sfc_map.vh on the include path and the checker bound to sfc_top
`include "sfc_map.vh"

module tb_spi_frame_check_swe_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SCR = `SFC_ADDR_SCRATCH_PAD;
  localparam logic [6:0] INT1 = `SFC_ADDR_INT_STAT_ONE;
  localparam logic [6:0] INT2 = `SFC_ADDR_INT_STAT_TWO;
  localparam logic [6:0] CFG = `SFC_ADDR_TIMER_CFG;
  logic        ref_clk, srst, pin, uv, wd, wake, fsf, en, sdo_oe;
  logic        spi_cs_n, spi_sclk, spi_sdi, spi_sdo, rd_valid, running, reset_out_low;
  // released sdo line shows the inverse of the last bit, so late sampling is caught
  wire         sdo_line = sdo_oe ? spi_sdo : ~spi_sdo;
  logic [15:0] rd_data, bad;
  logic [1:0]  device_mode;
  logic [31:0] rnd = 32'hEA80BDDD;
  bit          crc_on, alt;
  int          bad_count, n_tests;
  logic [15:0] exp_q[$];

  sfc_top #(.TICK_CYCLES(4)) uut (.ref_clk, .srst, .clk_en(en), .spi_cs_n, .spi_sclk,
    .spi_sdi, .spi_sdo, .spi_sdo_oe(sdo_oe), .pin_control(pin), .regulated_supply_undervoltage(uv),
    .watchdog_error(wd), .wake_event(wake), .fail_safe_fault(fsf), .device_mode,
    .sleep_wake_error_timer_running(running), .reset_out_low);
  sfc_host_model host (.ref_clk, .spi_sdo(sdo_line), .spi_cs_n, .spi_sclk, .spi_sdi, .rd_valid,
    .rd_data);
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? (alt ? 8'h1D : 8'h2F) : 8'h00);
    return c ^ 8'hFF;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // register access; reads note the expected data and reply crc
  task automatic xf(input logic [6:0] a, input bit w, input logic [7:0] d);
    logic [15:0] hd;
    hd = {a, w, w ? d : 8'h00};
    if (!w)
      exp_q.push_back({d, crc_on ? crc8({a, 1'b0, d}) : 8'h00});
    host.xfer(crc_on ? 24 : 16, {hd, crc8(hd), 8'h00}, !w);
  endtask
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int k;
    k = 0;
    while (device_mode !== m && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    check(device_mode, m);
  endtask
  task automatic pulse_wd();
    wd = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(reset_out_low, 0);
    wd = 1'b0;
    wait_mode(`SFC_MODE_STANDBY, 20);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (rd_valid === 1'b1)
      check(rd_data, exp_q.pop_front());
  initial begin
    #400000;
    bad_count++;
    finish_test();
  end
  ////////////////////////////////////////
  initial begin
    {srst, pin, uv, wd, wake, fsf} = 6'b100000;
    en = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(reset_out_low, 0);
    srst = 1'b0;
    repeat (12) @(negedge ref_clk);
    check(device_mode, `SFC_MODE_STANDBY);
    check(reset_out_low, 1);
    xf(CFG, 0, `SFC_CFG_RESET);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      xf(SCR, 1, rnd[7:0]);
      xf(SCR, 0, rnd[7:0]);
    end
    $display("scratchpad test done");
    bad = {SCR, 1'b1, ~rnd[7:0]};
    host.xfer(15, {bad, 16'h0}, 0);
    host.xfer(17, {bad, 16'h0}, 0);
    xf(SCR, 0, rnd[7:0]);
    xf(INT1, 0, 8'h90);
    xf(INT2, 0, 8'h80);
    xf(INT1, 1, 8'hFF);
    xf(INT2, 1, 8'hFF);
    xf(INT2, 0, 8'h00);
    $display("frame length test done");
    xf(`SFC_ADDR_CRC_CTRL, 1, 8'h01);
    crc_on = 1'b1;
    for (int p = 0; p < 2; p++) begin
      xf(`SFC_ADDR_CRC_SEL, 1, 8'(p));
      alt = p[0];
      rnd = lfsr(rnd);
      xf(SCR, 1, rnd[7:0]);
      xf(SCR, 0, rnd[7:0]);
    end
    bad = {SCR, 1'b1, ~rnd[7:0]};
    host.xfer(24, {bad, crc8(bad) ^ 8'h01, 8'h00}, 0);
    xf(SCR, 0, rnd[7:0]);
    xf(INT1, 0, 8'h90);
    xf(INT2, 0, 8'h10);
    host.xfer(16, {bad, 16'h0}, 0);
    xf(INT2, 0, 8'h90);
    xf(INT1, 1, 8'hFF);
    xf(INT2, 1, 8'hFF);
    xf(`SFC_ADDR_CRC_CTRL, 1, 8'h00);
    crc_on = 1'b0;
    $display("crc test done");
    xf(CFG, 1, 8'h18);
    pulse_wd();
    repeat (400) @(negedge ref_clk);
    check(device_mode, `SFC_MODE_STANDBY);
    wait_mode(`SFC_MODE_FAILSAFE, 150);
    wait_mode(`SFC_MODE_SLEEP, 600);
    uv = 1'b1;
    wake = 1'b1;
    wait_mode(`SFC_MODE_RESTART, 20);
    wake = 1'b0;
    wait_mode(`SFC_MODE_SLEEP, 600);
    uv = 1'b0;
    wake = 1'b1;
    wait_mode(`SFC_MODE_STANDBY, 20);
    wake = 1'b0;
    xf(SCR, 0, rnd[7:0]);
    repeat (600) @(negedge ref_clk);
    check(device_mode, `SFC_MODE_STANDBY);
    xf(CFG, 1, 8'h98);
    pulse_wd();
    repeat (600) @(negedge ref_clk);
    check(device_mode, `SFC_MODE_STANDBY);
    en = 1'b0;
    fsf = 1'b1;
    repeat (10) @(negedge ref_clk);
    check(device_mode, `SFC_MODE_STANDBY);
    fsf = 1'b0;
    en = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(device_mode, `SFC_MODE_STANDBY);
    pin = 1'b1;
    fsf = 1'b1;
    wait_mode(`SFC_MODE_FAILSAFE, 20);
    fsf = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(running, 1);
    wait_mode(`SFC_MODE_SLEEP, 1300);
    $display("timer test done");
    repeat (20) @(negedge ref_clk);
    finish_test();
  end
endmodule
